// >>> inc/ptm_defs.svh
// Purpose: Shared constants of the periodic timer mode logic
// Assumes: Included by the package and the design files by bare name
// Notes: Definitions only
`ifndef PTM_DEFS_SVH
`define PTM_DEFS_SVH

// Counter geometry
`define PTM_CNT_W 10
`define PTM_CNT_MAX 10'h3ff
`define PTM_CNT_ZERO 10'h000

// Mode select encodings
`define PTM_MODE_CMP 2'h0
`define PTM_MODE_CAP 2'h1
`define PTM_MODE_PWM 2'h2
`define PTM_MODE_TMR 2'h3

// Pin function in compare-match output mode
`define PTM_PF_NONE 2'h0
`define PTM_PF_LOW 2'h1
`define PTM_PF_HIGH 2'h2
`define PTM_PF_TOGGLE 2'h3

// Pin function in PWM / single-pulse mode
`define PTM_PF_INACTIVE 2'h0
`define PTM_PF_ACTIVE 2'h1
`define PTM_PF_PWM 2'h2
`define PTM_PF_PULSE 2'h3

// Reset values
`define PTM_RST_RUN 1'h0
`define PTM_RST_PIN 1'h0
`define PTM_RST_FLAG 1'h0

`endif

// >>> inc/ptm_pkg.sv
// Purpose: Types of the periodic timer mode logic
// Assumes: ptm_defs.svh on the include path
// Notes: Holds the state record and the counter step
`include "ptm_defs.svh"

package ptm_pkg;

  // Whole state of the timer core
  typedef struct packed {
    logic [`PTM_CNT_W-1:0] count;
    logic run;
    logic ext_prev;
    logic pin;
    logic flag_a;
    logic flag_p;
  } ptm_state_t;

  // Next count, wraps past the maximum to zero
  function automatic logic [`PTM_CNT_W-1:0] ptm_inc(input logic [`PTM_CNT_W-1:0] c);
    ptm_inc = c + 10'h001;
  endfunction

endpackage

// >>> src/ptm_cmp.sv
// Purpose: One comparator of the periodic timer
// Assumes: Fed with the count that the next tick would load
// Notes: A zero value may be barred from matching
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defs.svh"

module ptm_cmp
  import ptm_pkg::*;
(
  // Operands
  input wire logic [`PTM_CNT_W-1:0] next_count,
  input wire logic [`PTM_CNT_W-1:0] cmp_value,
  input wire logic zero_allowed,
  // Result
  output logic hit
);

  // Zero compare means "wrap at maximum"; only allowed where the caller wants it
  assign hit = (next_count == cmp_value) && (zero_allowed || (cmp_value != `PTM_CNT_ZERO));

endmodule

`default_nettype wire

// >>> src/ptm_timer.sv
// Purpose: Operating-mode core of a 10-bit periodic timer
// Assumes: tick is a one-cycle enable at the selected timer clock rate
// Notes: Capture mode is not covered; the counter just holds its value there
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defs.svh"

// Contract
// [RULE1] Mode select 00 gives compare-match output mode.
// [RULE2] Clear-source low: clear on P match or overflow when P zero; both flags raised.
// [RULE3] Clear-source high: clear on A match; only the A flag is raised.
// [RULE4] Compare A zero: counter overflows at 3FF and no A flag.
// [RULE5] Compare mode: pin changes only on A match, P matches ignored.
// [RULE6] Compare mode: A match drives pin high, low or toggles per pin function.
// [RULE7] Run bit rising edge sets pin to the output-control level.
// [RULE8] Mode 11 counts like compare mode but leaves the pin undriven.
// [RULE9] Software selects PWM with mode 10 and pin function 10.
// [RULE10] PWM: P sets period by clearing, A sets duty; clear-source ignored.
// [RULE11] PWM period equals P for 1..1023, and 1024 for P zero.
// [RULE12] Duty at or above period keeps output active whole period.
// [RULE13] PWM raises A flag on A match and P flag on P match.
// [RULE14] PWM pin function 00/01 force inactive/active; counting continues.
// [RULE15] PWM: output-control picks active level, invert bit flips the pin.
// [RULE16] Software selects single pulse with mode 10, pin function 11, unchanged.
// [RULE17] Single pulse: run rising, by software or ext pin edge, starts pulse.
// [RULE18] Single pulse: A match clears run, ends pulse, raises A flag.
// [RULE19] Single pulse: counter zeroed only on run rising; P, clear-source ignored.
// [RULE20] Software keeps compare A nonzero when expecting A clears or flags.
// [RULE21] Compare pin function: 00 none, 01 low, 10 high, 11 toggle.
// [RULE22] Software stops the timer before changing mode or PWM pin function.
// [RULE23] Running counter advances each tick; stopped counter holds. In capture mode 01 the running counter holds instead.
// [RULE24] Match is count equal to compare value, effective on that tick.
module ptm_timer
  import ptm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Timer clock enable
  input wire logic tick,
  // Configuration
  input wire logic mode_select_hi,
  input wire logic mode_select_lo,
  input wire logic pin_function_hi,
  input wire logic pin_function_lo,
  input wire logic output_control_bit,
  input wire logic output_invert_bit,
  input wire logic clear_source_select,
  input wire logic [`PTM_CNT_W-1:0] compare_a_value,
  input wire logic [`PTM_CNT_W-1:0] compare_p_value,
  // Run bit write port
  input wire logic run_wr,
  input wire logic run_wdata,
  // Flag clear strobes
  input wire logic cmp_a_flag_clr,
  input wire logic cmp_p_flag_clr,
  // External trigger pin
  input wire logic ext_clock_pin,
  // Status
  output logic run_bit,
  output logic [`PTM_CNT_W-1:0] counter_value,
  output logic cmp_a_flag,
  output logic cmp_p_flag,
  // Output pin
  output logic out_pin_o,
  output logic out_pin_oe
);

  ptm_state_t st_ff;
  ptm_state_t nxt_st;
  logic [1:0] mode;
  logic [1:0] pin_fn;
  logic [`PTM_CNT_W-1:0] cnt_next;
  logic hit_a;
  logic hit_p;
  logic sp_mode;
  logic ext_edge;
  logic start;
  logic stop_sw;
  logic counting;
  logic set_a;
  logic set_p;
  logic pwm_active;

  // Field gathering
  assign mode = {mode_select_hi, mode_select_lo};
  assign pin_fn = {pin_function_hi, pin_function_lo};
  assign cnt_next = ptm_inc(st_ff.count);
  assign sp_mode = (mode == `PTM_MODE_PWM) && (pin_fn == `PTM_PF_PULSE);
  assign ext_edge = ext_clock_pin && !st_ff.ext_prev;

  // Run bit rising edge, from software or, in single pulse, the ext pin
  assign start = !st_ff.run && ((run_wr && run_wdata) || (sp_mode && ext_edge)); // [RULE17]
  assign stop_sw = st_ff.run && run_wr && !run_wdata;
  assign counting = st_ff.run && tick && !stop_sw; // [RULE23]

  // Comparator A never matches at zero, so a zero A just rides the overflow
  ptm_cmp u_cmp_a (
    .next_count(cnt_next),
    .cmp_value(compare_a_value),
    .zero_allowed(1'h0),
    .hit(hit_a)
  ); // [RULE4] [RULE24]

  // Comparator P at zero matches on the wrap, giving overflow clear / 1024 period
  ptm_cmp u_cmp_p (
    .next_count(cnt_next),
    .cmp_value(compare_p_value),
    .zero_allowed(1'h1),
    .hit(hit_p)
  ); // [RULE11] [RULE24]

  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_prev = ext_clock_pin;
    set_a = 1'h0;
    set_p = 1'h0;
    pwm_active = 1'h0;
    if (start) begin
      nxt_st.run = 1'h1;
      nxt_st.pin = output_control_bit; // [RULE7]
      if (sp_mode) begin
        nxt_st.count = `PTM_CNT_ZERO; // [RULE19]
      end
    end else if (stop_sw) begin
      nxt_st.run = 1'h0; // [RULE18]
    end else if (counting) begin
      nxt_st.count = cnt_next; // [RULE23]
      case (mode)
        `PTM_MODE_CMP, `PTM_MODE_TMR: begin // [RULE1] [RULE8]
          if (clear_source_select) begin
            if (hit_a) begin
              nxt_st.count = `PTM_CNT_ZERO; // [RULE3]
              set_a = 1'h1;
            end
          end else begin
            if (hit_p) begin
              nxt_st.count = `PTM_CNT_ZERO; // [RULE2]
              set_p = 1'h1;
            end
            set_a = hit_a; // [RULE2]
          end
          // Only an A match moves the pin; P matches never touch it
          if (set_a && (mode == `PTM_MODE_CMP)) begin // [RULE5]
            case (pin_fn) // [RULE6] [RULE21]
              `PTM_PF_LOW: nxt_st.pin = 1'h0;
              `PTM_PF_HIGH: nxt_st.pin = 1'h1;
              `PTM_PF_TOGGLE: nxt_st.pin = !st_ff.pin;
              default: nxt_st.pin = st_ff.pin;
            endcase
          end
        end
        `PTM_MODE_PWM: begin
          if (sp_mode) begin
            // P and clear-source play no part; A ends the pulse
            if (hit_a) begin
              nxt_st.run = 1'h0; // [RULE18]
              set_a = 1'h1;
            end
          end else begin
            if (hit_p) begin
              nxt_st.count = `PTM_CNT_ZERO; // [RULE10] [RULE11]
              set_p = 1'h1; // [RULE13]
            end
            set_a = hit_a; // [RULE13]
          end
        end
        default: nxt_st.count = st_ff.count;
      endcase
    end
    // Waveform level; computed from the next count so the pin is a flop
    if (mode == `PTM_MODE_PWM) begin
      case (pin_fn)
        `PTM_PF_INACTIVE: pwm_active = 1'h0; // [RULE14]
        `PTM_PF_ACTIVE: pwm_active = 1'h1; // [RULE14]
        `PTM_PF_PWM: pwm_active = nxt_st.run && (nxt_st.count < compare_a_value); // [RULE12]
        default: pwm_active = nxt_st.run; // [RULE17] [RULE18]
      endcase
      nxt_st.pin = pwm_active ? output_control_bit : !output_control_bit; // [RULE15]
    end
    // Set wins over a clear arriving in the same cycle
    nxt_st.flag_a = set_a || (st_ff.flag_a && !cmp_a_flag_clr);
    nxt_st.flag_p = set_p || (st_ff.flag_p && !cmp_p_flag_clr);
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{count: `PTM_CNT_ZERO, run: `PTM_RST_RUN, ext_prev: 1'h0,
                 pin: `PTM_RST_PIN, flag_a: `PTM_RST_FLAG, flag_p: `PTM_RST_FLAG};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs; pin is left to general I/O in timer and capture modes
  assign run_bit = st_ff.run;
  assign counter_value = st_ff.count;
  assign cmp_a_flag = st_ff.flag_a;
  assign cmp_p_flag = st_ff.flag_p;
  assign out_pin_o = st_ff.pin ^ output_invert_bit; // [RULE15]
  assign out_pin_oe = (mode == `PTM_MODE_CMP) || (mode == `PTM_MODE_PWM); // [RULE8]

  // Checks
  run_start_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE7]
    (start && mode == `PTM_MODE_CMP) |=> (st_ff.pin == $past(output_control_bit)))
    else $error("pin not set to initial level on run rise");

  p_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE2]
    (counting && !start && mode == `PTM_MODE_CMP && !clear_source_select && hit_p)
      |=> (st_ff.count == `PTM_CNT_ZERO) && st_ff.flag_p)
    else $error("P match did not clear counter and flag");

  no_p_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE3]
    (mode == `PTM_MODE_CMP && clear_source_select && !st_ff.flag_p)
      |=> !st_ff.flag_p)
    else $error("P flag raised with A clear source");

  a_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE4]
    (compare_a_value == `PTM_CNT_ZERO && !st_ff.flag_a) |=> !st_ff.flag_a)
    else $error("A flag raised with zero compare A");

  pin_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE5]
    (mode == `PTM_MODE_CMP && !start && !(counting && hit_a))
      |=> (st_ff.pin == $past(st_ff.pin)))
    else $error("compare pin moved without A match");

  tmr_oe_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE8]
    (mode == `PTM_MODE_TMR) |-> !out_pin_oe)
    else $error("pin driven in timer mode");

  pwm_period_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE11]
    (counting && !start && mode == `PTM_MODE_PWM && pin_fn == `PTM_PF_PWM && hit_p)
      |=> (st_ff.count == `PTM_CNT_ZERO) && st_ff.flag_p)
    else $error("PWM period not closed by P match");

  pwm_full_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE12]
    (st_ff.run && !run_wr && mode == `PTM_MODE_PWM && pin_fn == `PTM_PF_PWM
      && compare_p_value != `PTM_CNT_ZERO && compare_a_value >= compare_p_value)
      |=> (st_ff.pin == $past(output_control_bit)))
    else $error("full duty PWM went inactive");

  sp_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE18]
    (counting && !start && sp_mode && hit_a) |=> (!st_ff.run && st_ff.flag_a))
    else $error("single pulse not ended by A match");

  hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE23]
    (!st_ff.run && !start) |=> (st_ff.count == $past(st_ff.count)))
    else $error("stopped counter moved");

  flag_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // [RULE13]
    (set_a && cmp_a_flag_clr) |=> st_ff.flag_a)
    else $error("A flag set lost to clear");

endmodule

`default_nettype wire

// >>> sim/ptm_timer_test.sv
// Purpose: Self-checking bench of the periodic timer mode logic
// Assumes: Design assertions live in the design files
// Notes: Reset state first, then table rows, then restart, flag clear and trigger cases
`timescale 1ns/1ps
`default_nettype none
`include "ptm_defs.svh"

module ptm_timer_test;
  typedef struct packed {
    logic [1:0] mode, pf;
    logic oc, inv, ccs;
    logic [9:0] a, p;
    logic [10:0] n;
    logic [9:0] cnt;
    logic fa, fp, pin, oe, run;
  } ptm_row_t;

  // Mode, pin fn, oc, inv, clr src, A, P, ticks, then count, flags, pin, oe, run
  localparam ptm_row_t rows [16] = '{
    '{2'h0, 2'h3, 1'h0, 1'h0, 1'h0, 10'h2, 10'h3, 11'h5, 10'h2, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1},
    '{2'h0, 2'h1, 1'h1, 1'h0, 1'h1, 10'h4, 10'h2, 11'h4, 10'h0, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
    '{2'h0, 2'h2, 1'h0, 1'h0, 1'h0, 10'h0, 10'h5, 11'h7, 10'h2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1},
    '{2'h0, 2'h2, 1'h0, 1'h0, 1'h0, 10'h0, 10'h0, 11'h401, 10'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1},
    '{2'h3, 2'h3, 1'h1, 1'h0, 1'h0, 10'h2, 10'h3, 11'h3, 10'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1},
    '{2'h0, 2'h0, 1'h1, 1'h0, 1'h0, 10'h2, 10'h3, 11'h3, 10'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1},
    '{2'h0, 2'h2, 1'h0, 1'h1, 1'h0, 10'h1, 10'h4, 11'h1, 10'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
    '{2'h2, 2'h2, 1'h1, 1'h0, 1'h1, 10'h2, 10'h5, 11'h6, 10'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1},
    '{2'h2, 2'h2, 1'h1, 1'h0, 1'h0, 10'h2, 10'h5, 11'h3, 10'h3, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1},
    '{2'h2, 2'h2, 1'h0, 1'h1, 1'h0, 10'h2, 10'h5, 11'h6, 10'h1, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1},
    '{2'h2, 2'h2, 1'h1, 1'h0, 1'h0, 10'h5, 10'h5, 11'h9, 10'h4, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1},
    '{2'h2, 2'h2, 1'h1, 1'h0, 1'h0, 10'h3, 10'h0, 11'h402, 10'h2, 1'h1, 1'h1, 1'h1, 1'h1, 1'h1},
    '{2'h2, 2'h0, 1'h1, 1'h0, 1'h0, 10'h2, 10'h5, 11'h6, 10'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1},
    '{2'h2, 2'h1, 1'h1, 1'h0, 1'h0, 10'h2, 10'h5, 11'h3, 10'h3, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1},
    '{2'h2, 2'h3, 1'h1, 1'h0, 1'h1, 10'h3, 10'h7, 11'h5, 10'h3, 1'h1, 1'h0, 1'h0, 1'h1, 1'h0},
    '{2'h1, 2'h0, 1'h0, 1'h0, 1'h0, 10'h2, 10'h3, 11'h4, 10'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1}
  };

  logic ref_clk = 1'h0, rst_n = 1'h0, tick = 1'h0, mh = 1'h0, ml = 1'h0, ph = 1'h0, pl = 1'h0;
  logic oc = 1'h0, inv = 1'h0, ccs = 1'h0, run_wr = 1'h0, run_wdata = 1'h0;
  logic clr_a = 1'h0, clr_p = 1'h0, ext = 1'h0;
  logic [9:0] ca = 10'h0, cp = 10'h0, cnt;
  logic run, fa, fp, pin, oe;
  int mismatches = 0, num_checks = 0;
  ptm_row_t r;

  ptm_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .tick(tick), .mode_select_hi(mh),
    .mode_select_lo(ml), .pin_function_hi(ph), .pin_function_lo(pl), .output_control_bit(oc),
    .output_invert_bit(inv), .clear_source_select(ccs), .compare_a_value(ca),
    .compare_p_value(cp), .run_wr(run_wr), .run_wdata(run_wdata), .cmp_a_flag_clr(clr_a),
    .cmp_p_flag_clr(clr_p), .ext_clock_pin(ext), .run_bit(run), .counter_value(cnt),
    .cmp_a_flag(fa), .cmp_p_flag(fp), .out_pin_o(pin), .out_pin_oe(oe));

  // 50 MHz reference clock
  always #10 ref_clk = ~ref_clk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Inputs move on the falling edge only, away from the sampling edge
  task automatic do_rst(input int n);
    rst_n = 1'h0;
    repeat (n) @(negedge ref_clk);
    rst_n = 1'h1;
  endtask

  task automatic run_w(input logic v);
    run_wr = 1'h1;
    run_wdata = v;
    @(negedge ref_clk);
    run_wr = 1'h0;
  endtask

  task automatic ticks(input int n);
    tick = 1'h1;
    repeat (n) @(negedge ref_clk);
    tick = 1'h0;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog, far beyond the roughly 2200 cycles the run needs
  initial begin
    #200000;
    mismatches++;
    end_of_test;
  end

  // Main sequence
  initial begin
    inv = 1'h1;
    @(negedge ref_clk);
    do_rst(16);
    chk({run, fa, fp, pin}, 4'h1);
    chk(cnt, 10'h0);
    inv = 1'h0;
    foreach (rows[i]) begin
      r = rows[i];
      // Reset stops the timer before every reconfiguration
      do_rst(2);
      {mh, ml} = r.mode;
      {ph, pl} = r.pf;
      {oc, inv, ccs} = {r.oc, r.inv, r.ccs};
      ca = r.a;
      cp = r.p;
      run_w(1'h1);
      ticks(int'(r.n));
      chk(cnt, r.cnt);
      chk({fa, fp}, {r.fa, r.fp});
      chk(run, r.run);
      chk(oe, r.oe);
      if (r.oe) chk(pin, r.pin);
    end
    // Toggle, stop, hold, restart back to initial level, flag clear
    do_rst(2);
    {mh, ml, ph, pl, oc, inv, ccs} = 7'h18;
    ca = 10'h1;
    cp = 10'h4;
    run_w(1'h1);
    ticks(1);
    chk(pin, 1'h1);
    run_w(1'h0);
    ticks(3);
    chk({run, cnt}, 11'h001);
    run_w(1'h1);
    chk(pin, 1'h0);
    clr_a = 1'h1;
    @(negedge ref_clk);
    clr_a = 1'h0;
    chk(fa, 1'h0);
    // P wrap, then an A match landing on an A clear: the set must win
    ticks(3);
    chk({fp, cnt}, 11'h400);
    {clr_a, clr_p, tick} = 3'h7;
    @(negedge ref_clk);
    {clr_a, clr_p, tick} = 3'h0;
    chk({fa, fp, pin, cnt}, 13'h1401);
    // Mid-run reset; trigger pin has no say outside single pulse
    do_rst(2);
    ext = 1'h1;
    @(negedge ref_clk);
    chk({run, fa, fp, cnt}, 13'h0);
    // Single pulse started by the trigger pin, ended by software
    {mh, ml, ph, pl, oc, inv, ccs, ext} = 8'hb8;
    ca = 10'h9;
    @(negedge ref_clk);
    ext = 1'h1;
    @(negedge ref_clk);
    chk({run, pin}, 2'h3);
    ticks(3);
    chk({pin, cnt}, 11'h403);
    run_w(1'h0);
    chk({run, pin, fa}, 3'h0);
    ext = 1'h0;
    run_w(1'h1);
    chk(cnt, 10'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
